/* rtl/ddrot_defines.svh */
// Register offsets, field positions, reset values and counts for the pin output stage
`ifndef DDROT_DEFINES_SVH
`define DDROT_DEFINES_SVH

`define DDROT_ADDR_W          4
`define DDROT_OFS_CTRL        4'h0
`define DDROT_OFS_DIV         4'h4
`define DDROT_OFS_STATUS      4'h8
`define DDROT_OFS_SENT        4'hc

`define DDROT_CTRL_RUN        0
`define DDROT_CTRL_CE         1
`define DDROT_CTRL_SDR        2
`define DDROT_CTRL_OUT_LATCH  3
`define DDROT_CTRL_TRI_LATCH  4
`define DDROT_CTRL_W          5
`define DDROT_CTRL_RST        5'h06

`define DDROT_DIV_W           8
`define DDROT_DIV_RST         8'h01

`define DDROT_ST_PAD          0
`define DDROT_ST_TRI          1
`define DDROT_ST_IOCLK        2
`define DDROT_ST_FULL         3
`define DDROT_ST_EMPTY        4
`define DDROT_ST_LVL_LO       5
`define DDROT_ST_OUT_HOLD     7
`define DDROT_ST_TRI_HOLD     8
`define DDROT_ST_UNDER_LO     16

`define DDROT_CNT_W           16
`define DDROT_BUF_DEPTH       2

`endif

/* rtl/ddrot_pkg.sv */
// Types shared by the pin output stage
package ddrot_pkg;
	`include "ddrot_defines.svh"

	// One word from the core: both data halves and both tristate halves
	typedef struct packed {
		logic tri_ctl_second;
		logic tri_ctl_first;
		logic out_data_second;
		logic out_data_first;
	} ddrot_word_s;

	typedef struct packed {
		logic tri_latch;
		logic out_latch;
		logic single_rate_mode;
		logic ce;
		logic run;
	} ddrot_ctrl_s;

	typedef logic [`DDROT_DIV_W-1:0] ddrot_div_t;
endpackage

/* rtl/ddrot_buf.sv */
// Small valid/ready buffer held in flip-flops
`timescale 1ns/100ps
module ddrot_buf #(
	parameter int WIDTH = 4,
	parameter int DEPTH = 2
) (
	input  wire logic             hclk,       // Clock
	input  wire logic             hresetn,    // Async reset, active low
	input  wire logic             in_valid,   // Source offers a word
	output logic                  in_ready,   // Room for a word
	input  wire logic [WIDTH-1:0] in_data,    // Word offered
	output logic                  out_valid,  // Head word present
	input  wire logic             out_ready,  // Drain takes the head
	output logic      [WIDTH-1:0] out_data,   // Head word
	output logic [$clog2(DEPTH+1)-1:0] level  // Words held
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int LW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0]    wr_reg;
	logic [PW-1:0]    rd_reg;
	logic [LW-1:0]    cnt_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_reg != LW'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rd_reg];
	assign level     = cnt_reg;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PW'(DEPTH-1)) ? '0 : p + PW'(1);
	endfunction

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
		end
		else
		begin
			if (push)
				wr_reg <= bump(wr_reg);
			if (pop)
				rd_reg <= bump(rd_reg);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cnt_reg <= '0;
		else if (push && !pop)
			cnt_reg <= cnt_reg + LW'(1);
		else if (pop && !push)
			cnt_reg <= cnt_reg - LW'(1);
	end

	// Storage needs no reset; nothing reads a slot before it is written
	always_ff @(posedge hclk)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end
endmodule

/* rtl/ddrot_path.sv */
// One pin path: single rate element, double rate latch and clock-driven mux
`timescale 1ns/100ps
module ddrot_path (
	input  wire logic hclk,        // Clock
	input  wire logic hresetn,     // Async reset, active low
	input  wire logic io_clk,      // Edge clock level
	input  wire logic io_rise,     // Edge clock rises after this cycle
	input  wire logic sdr_mode,    // 1 single rate, 0 double rate
	input  wire logic latch_mode,  // Single rate element as latch
	input  wire logic ce,          // Clock enable of the single rate element
	input  wire logic take,        // A word is present to capture
	input  wire logic d_first,     // First input
	input  wire logic d_second,    // Second input
	output logic      hold,        // Double rate latch content
	output logic      q            // Registered pin value
);
	logic sdr_reg;
	logic stage_reg;
	logic hold_reg;
	logic latch_out;
	logic q_next;

	// Single rate element: edge or transparent-low latch, with reset and enable
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sdr_reg <= 1'b0;
		else if (ce && take)
		begin
			if (sdr_mode && latch_mode && !io_clk)
				sdr_reg <= d_first;
			else if (io_rise)
				sdr_reg <= d_first;
		end
	end

	// Second half captured with the first so the pair leaves together
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			stage_reg <= 1'b0;
		else if (ce && take && io_rise && !sdr_mode)
			stage_reg <= d_second;
	end

	// Double rate latch: no reset, no enable, follows while the clock is low
	always_ff @(posedge hclk)
	begin
		if (!io_clk)
			hold_reg <= stage_reg;
	end

	assign latch_out = io_clk ? hold_reg : stage_reg;
	assign hold      = hold_reg;

	always_comb
	begin
		if (sdr_mode)
			q_next = sdr_reg;
		else
			q_next = io_clk ? sdr_reg : latch_out;
	end

	// Retiming flop keeps the pin defined before the latch first loads
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			q <= 1'b0;
		else
			q <= q_next;
	end
endmodule

/* rtl/ddrot_top.sv */
// Pin output and tristate register stage with AHB-Lite control
//
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`include "ddrot_defines.svh"
module ddrot_top #(
	parameter int BUF_DEPTH = `DDROT_BUF_DEPTH,
	parameter int CNT_W     = `DDROT_CNT_W
) (
	input  wire logic               hclk,        // Bus and stage clock
	input  wire logic               hresetn,     // Async reset, active low
	input  wire logic               hsel,        // Slave select
	input  wire logic [31:0]        haddr,       // Byte address
	input  wire logic [1:0]         htrans,      // Transfer type
	input  wire logic               hwrite,      // Write when high
	input  wire logic [2:0]         hsize,       // Transfer size
	input  wire logic               hready,      // Bus ready
	input  wire logic [31:0]        hwdata,      // Write data
	output logic                    hreadyout,   // Slave ready
	output logic                    hresp,       // Response, always OKAY
	output logic [31:0]             hrdata,      // Read data
	input  wire logic               core_valid,  // Core offers a word
	output logic                    core_ready,  // Stage accepts the word
	input  wire ddrot_pkg::ddrot_word_s core_word, // Data and tristate halves
	output logic                    io_clk,      // Edge clock driven to the pin cell
	output logic                    pad_drive_out, // Registered pad data
	output logic                    pad_tri_out  // Registered tristate, high releases pad
);
	import ddrot_pkg::*;

	localparam int LW = $clog2(BUF_DEPTH+1);

	ddrot_ctrl_s                ctrl_reg;
	ddrot_div_t                 div_reg;
	ddrot_div_t                 div_cnt_reg;
	logic                       io_clk_reg;
	logic                       io_tick;
	logic                       io_rise;
	logic [CNT_W-1:0]           sent_reg;
	logic [CNT_W-1:0]           under_reg;
	logic                       wr_pend_reg;
	logic [`DDROT_ADDR_W-1:0]   wr_addr_reg;
	logic [31:0]                hrdata_reg;
	logic                       addr_take;
	logic                       buf_valid;
	logic                       buf_ready;
	ddrot_word_s                buf_word;
	logic [LW-1:0]              buf_level;
	logic                       out_hold;
	logic                       tri_hold;
	logic                       take;
	logic                       sent_clr;
	logic                       under_clr;

	// Register decode used by the read mux; the write path compares wr_addr_reg itself
	function automatic logic is_reg(input logic [31:0] a, input logic [`DDROT_ADDR_W-1:0] ofs);
		is_reg = (a[31:`DDROT_ADDR_W] == '0) && (a[`DDROT_ADDR_W-1:0] == ofs);
	endfunction

	// AHB-Lite: zero wait states, writes land in the data phase
	assign addr_take = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
		end
		else
		begin
			wr_pend_reg <= addr_take && hwrite && (haddr[31:`DDROT_ADDR_W] == '0);
			wr_addr_reg <= haddr[`DDROT_ADDR_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl_reg <= `DDROT_CTRL_RST;
		else if (wr_pend_reg && wr_addr_reg == `DDROT_OFS_CTRL)
			ctrl_reg <= hwdata[`DDROT_CTRL_W-1:0];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			div_reg <= `DDROT_DIV_RST;
		else if (wr_pend_reg && wr_addr_reg == `DDROT_OFS_DIV)
			div_reg <= hwdata[`DDROT_DIV_W-1:0];
	end

	// Read data sampled in the address phase, shown in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_reg <= '0;
		else if (addr_take && !hwrite)
		begin
			hrdata_reg <= '0;
			if (is_reg(haddr, `DDROT_OFS_CTRL))
				hrdata_reg[`DDROT_CTRL_W-1:0] <= ctrl_reg;
			else if (is_reg(haddr, `DDROT_OFS_DIV))
				hrdata_reg[`DDROT_DIV_W-1:0] <= div_reg;
			else if (is_reg(haddr, `DDROT_OFS_STATUS))
			begin
				hrdata_reg[`DDROT_ST_PAD]   <= pad_drive_out;
				hrdata_reg[`DDROT_ST_TRI]   <= pad_tri_out;
				hrdata_reg[`DDROT_ST_IOCLK] <= io_clk_reg;
				// Full means no room for the core, not a stalled drain
				hrdata_reg[`DDROT_ST_FULL]  <= !core_ready;
				hrdata_reg[`DDROT_ST_EMPTY] <= !buf_valid;
				hrdata_reg[`DDROT_ST_LVL_LO +: LW]     <= buf_level;
				hrdata_reg[`DDROT_ST_OUT_HOLD]         <= out_hold;
				hrdata_reg[`DDROT_ST_TRI_HOLD]         <= tri_hold;
				hrdata_reg[`DDROT_ST_UNDER_LO +: CNT_W] <= under_reg;
			end
			else if (is_reg(haddr, `DDROT_OFS_SENT))
				hrdata_reg[CNT_W-1:0] <= sent_reg;
		end
	end

	// Edge clock from a divider; a zero divide acts as one
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_cnt_reg <= '0;
			io_clk_reg  <= 1'b0;
		end
		else if (!ctrl_reg.run)
		begin
			div_cnt_reg <= '0;
			io_clk_reg  <= 1'b0;
		end
		else if (io_tick)
		begin
			div_cnt_reg <= '0;
			io_clk_reg  <= !io_clk_reg;
		end
		else
			div_cnt_reg <= div_cnt_reg + `DDROT_DIV_W'(1);
	end

	assign io_tick = ctrl_reg.run && ((div_cnt_reg + `DDROT_DIV_W'(1)) >= div_reg);
	assign io_rise = io_tick && !io_clk_reg;
	assign io_clk  = io_clk_reg;

	// Core words pass a two-entry buffer; a disabled stage stalls the core
	ddrot_buf #(
		.WIDTH ($bits(ddrot_word_s)),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.in_valid  (core_valid),
		.in_ready  (core_ready),
		.in_data   (core_word),
		.out_valid (buf_valid),
		.out_ready (buf_ready),
		.out_data  (buf_word),
		.level     (buf_level)
	);

	// Word leaves the buffer only at an enabled rising edge
	assign take      = buf_valid;
	assign buf_ready = io_rise && ctrl_reg.ce;

	ddrot_path u_out (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.io_clk     (io_clk_reg),
		.io_rise    (io_rise),
		.sdr_mode   (ctrl_reg.single_rate_mode),
		.latch_mode (ctrl_reg.out_latch),
		.ce         (ctrl_reg.ce),
		.take       (take),
		.d_first    (buf_word.out_data_first),
		.d_second   (buf_word.out_data_second),
		.hold       (out_hold),
		.q          (pad_drive_out)
	);

	ddrot_path u_tri (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.io_clk     (io_clk_reg),
		.io_rise    (io_rise),
		.sdr_mode   (ctrl_reg.single_rate_mode),
		.latch_mode (ctrl_reg.tri_latch),
		.ce         (ctrl_reg.ce),
		.take       (take),
		.d_first    (buf_word.tri_ctl_first),
		.d_second   (buf_word.tri_ctl_second),
		.hold       (tri_hold),
		.q          (pad_tri_out)
	);

	// Counters clear on any write to their own register (SENT, STATUS); a count in the same cycle still lands
	assign sent_clr  = wr_pend_reg && wr_addr_reg == `DDROT_OFS_SENT;
	assign under_clr = wr_pend_reg && wr_addr_reg == `DDROT_OFS_STATUS;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sent_reg <= '0;
		else if (buf_valid && buf_ready)
			sent_reg <= sent_clr ? CNT_W'(1) : sent_reg + CNT_W'(1);
		else if (sent_clr)
			sent_reg <= '0;
	end

	// Enabled edge with nothing to send: the pins repeat the last word
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			under_reg <= '0;
		else if (buf_ready && !buf_valid)
			under_reg <= under_clr ? CNT_W'(1) : under_reg + CNT_W'(1);
		else if (under_clr)
			under_reg <= '0;
	end
endmodule

/* verification/ddrot_top_asserts.sv */
// Port checker for the pin output stage
`timescale 1ns/100ps
module ddrot_top_asserts #(
	parameter int BUF_DEPTH = 2,
	parameter int CNT_W     = 16
) (
	input wire logic        hclk,          // Clock
	input wire logic        hresetn,       // Reset
	input wire logic        hsel,          // Select
	input wire logic [31:0] haddr,         // Address
	input wire logic [1:0]  htrans,        // Transfer
	input wire logic        hwrite,        // Write
	input wire logic        hready,        // Bus ready
	input wire logic [31:0] hwdata,        // Write data
	input wire logic        hreadyout,     // Slave ready
	input wire logic        hresp,         // Response
	input wire logic        io_clk,        // Edge clock
	input wire logic        pad_drive_out, // Pad data
	input wire logic        pad_tri_out    // Pad tristate
);
	import ddrot_pkg::*;
	logic [4:0] ctrl_s;
	logic [7:0] div_s;
	logic [3:0] ofs_q;
	logic       wr_q;
	logic       io_q;
	logic [1:0] calm;
	logic [8:0] hi_cnt;
	// Shadow of the mode bits and the divide, seen from the bus writes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_q   <= 1'b0;
			ofs_q  <= 4'h0;
			ctrl_s <= 5'h06;
			div_s  <= 8'h01;
			calm   <= 2'h0;
		end
		else
		begin
			wr_q  <= hsel && hready && htrans[1] && hwrite;
			ofs_q <= haddr[3:0];
			calm  <= (wr_q && ofs_q == 4'h0) ? 2'h0 : calm + {1'b0, calm != 2'h3};
			if (wr_q && ofs_q == 4'h0)
				ctrl_s <= hwdata[4:0];
			if (wr_q && ofs_q == 4'h4)
				div_s <= hwdata[7:0];
		end
	end
	// High phase length, only for phases begun while running
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			io_q   <= 1'b0;
			hi_cnt <= 9'h000;
		end
		else
		begin
			io_q   <= io_clk;
			hi_cnt <= (!io_clk || !ctrl_s[0]) ? 9'h000 :
				hi_cnt + {8'h00, hi_cnt != 9'h000 || !io_q};
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_sdr_quiet;
		ctrl_s[2] && ctrl_s[4:3] == 2'h0 && calm == 2'h3;
	endsequence
	sequence s_high_ddr;
		(io_clk && !ctrl_s[2] && calm == 2'h3) [*3];
	endsequence
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_reset_idle: assert property ($rose(hresetn) |-> !pad_drive_out && !pad_tri_out && !io_clk)
		else $error("pins not low after reset");
	a_sdr_pad: assert property (s_sdr_quiet ##0 $changed(pad_drive_out) |-> $past(io_clk) && !$past(io_clk, 2))
		else $error("single rate pad moved off the rising edge");
	a_sdr_tri: assert property (s_sdr_quiet ##0 $changed(pad_tri_out) |-> $past(io_clk) && !$past(io_clk, 2))
		else $error("single rate tristate moved off the rising edge");
	a_ddr_pad_hold: assert property (s_high_ddr |-> $stable(pad_drive_out))
		else $error("double rate pad moved in high phase");
	a_ddr_tri_hold: assert property (s_high_ddr |-> $stable(pad_tri_out))
		else $error("double rate tristate moved in high phase");
	a_latch_hold: assert property ((io_clk && ctrl_s[3] && ctrl_s[2] && calm == 2'h3) [*3] |-> $stable(pad_drive_out) && $stable(pad_tri_out))
		else $error("latch not holding while clock high");
	a_ce_freeze: assert property ((!ctrl_s[1] && ctrl_s[2] && calm == 2'h3) [*3] |-> $stable(pad_drive_out) && $stable(pad_tri_out))
		else $error("single rate element moved without enable");
	// A stop forces the clock low early; such a cut phase is not judged
	a_clk_period: assert property ($fell(io_clk) && ctrl_s[0] && hi_cnt != 9'h000 |-> hi_cnt == ((div_s == 8'h00) ? 9'h001 : {1'b0, div_s}))
		else $error("edge clock high phase length wrong");
endmodule
bind ddrot_top ddrot_top_asserts #(.BUF_DEPTH(BUF_DEPTH), .CNT_W(CNT_W)) u_chk (.hclk, .hresetn,
	.hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hreadyout, .hresp, .io_clk,
	.pad_drive_out, .pad_tri_out);

/* verification/ddrot_core_src.sv */
// Core fabric source model feeding the stage
`timescale 1ns/100ps
module ddrot_core_src (
	input  wire logic                   hclk,       // Clock
	input  wire logic                   req,        // Send w
	input  wire ddrot_pkg::ddrot_word_s w,          // Word
	input  wire logic                   core_ready, // Stage room
	output logic                        core_valid, // Offer
	output ddrot_pkg::ddrot_word_s      core_word,  // Offered word
	output logic                        taken       // Accepted
);
	import ddrot_pkg::*;
	initial
	begin
		core_valid = 1'b0;
		core_word = '0;
		taken = 1'b0;
	end
	always @(posedge hclk)
	begin
		taken <= core_valid && core_ready;
		if (core_valid && core_ready)
		begin
			core_valid <= 1'b0;
			core_word <= ~core_word; // Released: no stale word left
		end
		else if (req && !core_valid && !taken && $urandom_range(1) == 1)
		begin
			core_valid <= 1'b1;
			core_word <= w;
		end
	end
endmodule

/* verification/test_ddrot_top.sv */
// Self-checking bench for the pin output stage
`timescale 1ns/100ps
module test_ddrot_top;
	import ddrot_pkg::*;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, core_valid, core_ready, io_clk, pad_drive_out, pad_tri_out;
	logic        req = 1'b0, taken, io_q = 1'b0, ce_m = 1'b1, sdr_m = 1'b1, run_m = 1'b0;
	ddrot_word_s core_word, w = '0, cur = '0;
	ddrot_word_s q[$];
	int          bad_count = 0, check_count = 0, ph = 0, sent_m = 0, under_m = 0;
	always #25 hclk = ~hclk;
	ddrot_top DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata, .core_valid, .core_ready,
		.core_word, .io_clk, .pad_drive_out, .pad_tri_out);
	ddrot_core_src src (.hclk, .req, .w, .core_ready, .core_valid, .core_word, .taken);
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Bounded wait for accept (sel 1) or bus ready (sel 0)
	task automatic wait_hi(input bit sel);
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while ((sel ? taken : hreadyout) !== 1'b1 && n < 40);
		if ((sel ? taken : hreadyout) !== 1'b1)
		begin
			bad_count++;
			$display("BAD %0t wait ran out", $time);
			complete_run;
		end
	endtask
	task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		wait_hi(0);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_hi(0);
	endtask
	task automatic rdreg(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
		bus(a, 1'b0, 32'h0);
		chk(hrdata & m, e & m);
	endtask
	task automatic send_words(input int k);
		ddrot_word_s x;
		repeat (k)
		begin
			x = 4'($urandom_range(15));
			w <= x;
			req <= 1'b1;
			wait_hi(1);
			q.push_back(x);
		end
		req <= 1'b0;
	endtask
	// Reference pin model: one word per enabled edge clock rise
	always @(posedge hclk)
	begin
		ph = (io_clk !== io_q) ? 0 : ph + 1;
		if (hresetn && io_clk && !io_q && ce_m)
		begin
			if (q.size() > 0)
			begin
				cur = q.pop_front();
				sent_m++;
			end
			else
				under_m++;
		end
		if (hresetn && ph == 2 && run_m)
		begin
			chk(pad_drive_out, (io_clk || sdr_m) ? cur.out_data_first : cur.out_data_second);
			chk(pad_tri_out, (io_clk || sdr_m) ? cur.tri_ctl_first : cur.tri_ctl_second);
		end
		io_q = io_clk;
	end
	initial
	begin
		void'($urandom(57933));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rdreg(32'h0, 32'h6, '1);
		rdreg(32'h4, 32'h1, '1);
		rdreg(32'h8, 32'h10, 32'hfffffe7f);
		rdreg(32'h100, 32'h0, '1);
		$display("reset test done");
		bus(32'h4, 1'b1, 32'h4);
		send_words(2);
		chk(core_ready, 1'b0);
		rdreg(32'h8, 32'h48, 32'hfffffe7f);
		bus(32'h0, 1'b1, 32'h1e);
		repeat (3) @(posedge hclk);
		chk(pad_drive_out, q[0].out_data_first);
		chk(pad_tri_out, q[0].tri_ctl_first);
		$display("fill and latch test done");
		bus(32'h0, 1'b1, 32'h7);
		run_m <= 1'b1;
		repeat (40) @(posedge hclk);
		bus(32'h0, 1'b1, 32'h6);
		run_m <= 1'b0;
		rdreg(32'hc, sent_m, '1);
		rdreg(32'h8, under_m << 16, 32'hffff0000);
		bus(32'hc, 1'b1, 32'h0);
		bus(32'h8, 1'b1, 32'h0);
		sent_m = 0;
		under_m = 0;
		rdreg(32'hc, 32'h0, '1);
		$display("single rate test done");
		send_words(1);
		ce_m <= 1'b0;
		bus(32'h0, 1'b1, 32'h5);
		run_m <= 1'b1;
		repeat (30) @(posedge hclk);
		bus(32'h0, 1'b1, 32'h4);
		run_m <= 1'b0;
		rdreg(32'hc, 32'h0, '1);
		ce_m <= 1'b1;
		bus(32'h0, 1'b1, 32'h1f);
		run_m <= 1'b1;
		repeat (30) @(posedge hclk);
		$display("enable and latch run test done");
		hresetn <= 1'b0;
		run_m <= 1'b0;
		repeat (3) @(posedge hclk);
		chk({io_clk, pad_drive_out, pad_tri_out, core_ready}, 4'h1);
		hresetn <= 1'b1;
		q.delete();
		cur = '0;
		sent_m = 0;
		rdreg(32'h0, 32'h6, '1);
		bus(32'h4, 1'b1, 32'h4);
		send_words(2);
		sdr_m <= 1'b0;
		bus(32'h0, 1'b1, 32'h3);
		run_m <= 1'b1;
		repeat (40) @(posedge hclk);
		bus(32'h0, 1'b1, 32'h2);
		run_m <= 1'b0;
		rdreg(32'hc, sent_m, '1);
		$display("double rate test done");
		complete_run;
	end
endmodule
